// ---- pds_params.svh ----
// Constants of the positioning data sequencer: offsets, fields, codes, times
// Assumes inclusion by bare name from every design file that needs it
// Functional notes
// [RL1] Hold up to 600 positioning items per axis, numbered from 1.
// [RL2] Each item has a three-code pattern choosing what follows completion.
// [RL3] Acceleration selector picks one of four times, used at motion start.
// [RL4] Deceleration selector picks one of four times, used at motion stop.
// [RL5] Dwell waits after motion completes before positioning complete.
// [RL6] Circular items use arc address as auxiliary or centre point.
// [RL7] Present the executing item's auxiliary code number.
// [RL8] Independent pattern runs one item; completion follows the full dwell.
// [RL9] Independent item ends the block; sequencing stops after it.
// [RL10] Continuous positioning decelerates to zero speed between items; the code enters dwell on move done whether or not speed_zero_i is set.
// [RL11] Continuous positioning delays next acceleration until dwell elapses.
// [RL12] Continuous positioning starts the next item with no new start.
// [RL13] Chain while pattern is a continue code; stop at independent.
// [RL14] Without a terminating item, chain to the highest number and stop.
// [RL15] Busy asserts even for a zero-amount position move, briefly.
// [RL16] Continuous path changes speed directly, no stop between items.
// [RL17] Continuous path ignores dwell time; the code still waits the dwell of a path item at the highest number.
// [RL18] Current index loads from start and increments on each chain.
// [RL19] The two continue codes differ; only positioning stops between items.
`ifndef PDS_PARAMS_SVH
`define PDS_PARAMS_SVH
`define PDS_ITEMS        600
`define PDS_IDX_W        10
`define PDS_PAT_INDEP    2'h0
`define PDS_PAT_CPOS     2'h1
`define PDS_PAT_CPATH    2'h3
`define PDS_CM_CIRC_AUX  4'h8
`define PDS_CM_CIRC_CTR  4'h9
`define PDS_DWELL_US     1000
`define PDS_CLK_MHZ      200
`define PDS_TICK_CYC     (`PDS_DWELL_US / 1000 * `PDS_CLK_MHZ * 1000 / 1000)
`define PDS_MS_CYC       200000
`define PDS_ADDR_CTRL    8'h00
`define PDS_ADDR_START   8'h04
`define PDS_ADDR_STAT    8'h08
`define PDS_ADDR_IRQ     8'h0c
`define PDS_ADDR_MASK    8'h10
`define PDS_ADDR_CUR     8'h14
`define PDS_ADDR_AUX     8'h18
`define PDS_ADDR_TSEL    8'h1c
`define PDS_ADDR_ARC     8'h20
`define PDS_ADDR_ACCV    8'h40
`define PDS_ADDR_DECV    8'h50
`define PDS_ADDR_TAB     8'h80
`define PDS_IRQ_DONE     0
`define PDS_IRQ_END      1
`define PDS_IRQ_STEP     2
`define PDS_IRQ_W        3
`endif

// ---- pds_pkg.sv ----
// Types of the positioning data sequencer
// Assumes pds_params.svh is available on the include path
`include "pds_params.svh"
package pds_pkg;
  typedef struct packed {
    logic [1:0]  pattern;
    logic [3:0]  method;
    logic [1:0]  accel_sel;
    logic [1:0]  decel_sel;
    logic [31:0] target;
    logic [31:0] arc;
    logic [31:0] speed;
    logic [15:0] dwell;
    logic [15:0] aux_code;
  } pds_item_t;
  typedef struct packed {
    logic        valid;
    logic [31:0] target;
    logic [31:0] speed;
    logic [31:0] accel_time;
    logic [31:0] decel_time;
    logic        stop_between;
  } pds_motion_t;
  typedef enum logic [4:0] {
    PDS_IDLE  = 5'b00001,
    PDS_FETCH = 5'b00010,
    PDS_MOVE  = 5'b00100,
    PDS_DWELL = 5'b01000,
    PDS_NEXT  = 5'b10000
  } pds_state_t;
endpackage

// ---- pds_dwell_timer.sv ----
// Dwell timer: counts milliseconds from a divided tick to the loaded amount
// Assumes a one-cycle load pulse and a tick enable on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "pds_params.svh"
module pds_dwell_timer #(
  parameter int TICK_CYC = `PDS_MS_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Control
  input  wire logic        load_i,
  input  wire logic [15:0] amount_i,
  // Result
  output logic             done_o
);
  logic [31:0] div_r;
  logic [15:0] left_r;
  logic        run_r;
  logic        tick;

  assign tick = (div_r == 32'(TICK_CYC - 1));

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_r <= 32'h0;
    end else if (load_i || tick) begin
      div_r <= 32'h0;
    end else if (run_r) begin
      div_r <= div_r + 32'h1;
    end
  end

  // Completion only after the whole amount has elapsed
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      left_r <= 16'h0;
      run_r  <= 1'b0;
      done_o <= 1'b0;
    end else if (load_i) begin
      left_r <= amount_i;
      run_r  <= (amount_i != 16'h0);
      done_o <= (amount_i == 16'h0);
    end else if (run_r && tick) begin
      left_r <= left_r - 16'h1;
      if (left_r == 16'h1) begin
        run_r  <= 1'b0;
        done_o <= 1'b1;
      end
    end else begin
      done_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- pds_sequencer.sv ----
// Positioning data sequencer for one axis with its register port
// Assumes a motion unit that reports completion and speed zero on clk_i
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pds_params.svh"
module pds_sequencer
  import pds_pkg::*;
#(
  parameter int ITEMS    = `PDS_ITEMS,
  parameter int TICK_CYC = `PDS_MS_CYC
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // Register port
  input  wire logic [15:0]       addr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic              we_i,
  input  wire logic              re_i,
  output logic [31:0]            rdata_o,
  // Motion unit
  output pds_pkg::pds_motion_t   motion_o,
  input  wire logic              move_done_i,
  input  wire logic              speed_zero_i,
  // Axis outputs
  output logic                   busy_o,
  output logic [15:0]            aux_code_o,
  output logic [31:0]            arc_point_o,
  output logic                   arc_center_o,
  output logic                   irq_o
);
  pds_item_t            tab_r [ITEMS];
  pds_item_t            item_r;
  pds_state_t           state_r;
  logic [`PDS_IDX_W-1:0] cur_r;
  logic [`PDS_IDX_W-1:0] start_idx_r;
  logic [31:0]          accel_v_r [4];
  logic [31:0]          decel_v_r [4];
  logic [`PDS_IRQ_W-1:0] irq_r;
  logic [`PDS_IRQ_W-1:0] mask_r;
  logic [`PDS_IRQ_W-1:0] ev;
  logic                 enable_r;
  logic                 start_req;
  logic                 dwell_load;
  logic                 dwell_done;
  logic                 at_last;
  logic [15:0]          slot;
  logic [2:0]           word;
  logic [`PDS_IDX_W-1:0] widx;
  logic                 tab_hit;

  // Table words: eight per item, item n at index n-1
  assign tab_hit = (addr_i[15:7] != 9'h0);
  assign slot    = (addr_i - 16'(`PDS_ADDR_TAB)) >> 5;
  assign word    = addr_i[4:2];
  assign widx    = slot[`PDS_IDX_W-1:0];
  assign start_req = we_i && (addr_i == 16'(`PDS_ADDR_START)) && enable_r &&
                     (state_r == PDS_IDLE) && (wdata_i[15:0] != 16'h0) &&
                     (wdata_i[15:0] <= 16'(ITEMS)); // see [RL1]
  assign at_last = (cur_r == `PDS_IDX_W'(ITEMS)); // see [RL14]

  always_ff @(posedge clk_i) begin
    if (we_i && tab_hit && (slot < 16'(ITEMS))) begin // see [RL1]
      case (word)
        3'h0: begin
          tab_r[widx].pattern   <= wdata_i[1:0]; // see [RL2]
          tab_r[widx].method    <= wdata_i[7:4];
          tab_r[widx].accel_sel <= wdata_i[9:8];
          tab_r[widx].decel_sel <= wdata_i[11:10];
        end
        3'h1: tab_r[widx].target   <= wdata_i;
        3'h2: tab_r[widx].arc      <= wdata_i;
        3'h3: tab_r[widx].speed    <= wdata_i;
        3'h4: tab_r[widx].dwell    <= wdata_i[15:0];
        3'h5: tab_r[widx].aux_code <= wdata_i[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 4; i++) begin
        accel_v_r[i] <= 32'h0;
        decel_v_r[i] <= 32'h0;
      end
    end else if (we_i && (addr_i[15:5] == 11'h2)) begin
      if (addr_i[4] == 1'b0) begin
        accel_v_r[addr_i[3:2]] <= wdata_i;
      end else begin
        decel_v_r[addr_i[3:2]] <= wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enable_r    <= 1'b0;
      start_idx_r <= `PDS_IDX_W'(1);
      mask_r      <= '0;
    end else if (we_i) begin
      if (addr_i == 16'(`PDS_ADDR_CTRL)) begin
        enable_r <= wdata_i[0];
      end
      if (addr_i == 16'(`PDS_ADDR_MASK)) begin
        mask_r <= wdata_i[`PDS_IRQ_W-1:0];
      end
      if (start_req) begin
        start_idx_r <= wdata_i[`PDS_IDX_W-1:0];
      end
    end
  end

  // Sequencing state
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= PDS_IDLE;
      cur_r   <= `PDS_IDX_W'(1);
      item_r  <= '0;
    end else begin
      case (state_r)
        PDS_IDLE: begin
          if (start_req) begin
            cur_r   <= wdata_i[`PDS_IDX_W-1:0]; // see [RL18]
            state_r <= PDS_FETCH;
          end
        end
        PDS_FETCH: begin
          item_r  <= tab_r[cur_r - `PDS_IDX_W'(1)];
          state_r <= PDS_MOVE;
        end
        PDS_MOVE: begin
          if (move_done_i) begin
            if (item_r.pattern == `PDS_PAT_CPATH && !at_last) begin
              state_r <= PDS_NEXT; // see [RL16] [RL17] [RL19]
            end else if (speed_zero_i) begin
              state_r <= PDS_DWELL; // see [RL5] [RL10]
            end else begin
              state_r <= PDS_DWELL;
            end
          end
        end
        PDS_DWELL: begin
          if (dwell_done) begin
            if (item_r.pattern == `PDS_PAT_INDEP || at_last) begin
              state_r <= PDS_IDLE; // see [RL8] [RL9] [RL14]
            end else begin
              state_r <= PDS_NEXT; // see [RL11] [RL12] [RL13]
            end
          end
        end
        PDS_NEXT: begin
          cur_r   <= cur_r + `PDS_IDX_W'(1); // see [RL18]
          state_r <= PDS_FETCH;
        end
        default: state_r <= PDS_IDLE;
      endcase
    end
  end

  assign dwell_load = (state_r == PDS_MOVE) && move_done_i &&
                      !(item_r.pattern == `PDS_PAT_CPATH && !at_last);

  pds_dwell_timer #(
    .TICK_CYC (TICK_CYC)
  ) u_dwell (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .load_i   (dwell_load),
    .amount_i (item_r.dwell),
    .done_o   (dwell_done)
  );

  // Motion command and item presentation
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      motion_o     <= '0;
      aux_code_o   <= 16'h0;
      arc_point_o  <= 32'h0;
      arc_center_o <= 1'b0;
    end else begin
      motion_o.valid <= (state_r == PDS_FETCH);
      if (state_r == PDS_MOVE && motion_o.valid) begin
        motion_o.target       <= item_r.target;
        motion_o.speed        <= item_r.speed;
        motion_o.accel_time   <= accel_v_r[item_r.accel_sel]; // see [RL3]
        motion_o.decel_time   <= decel_v_r[item_r.decel_sel]; // see [RL4]
        motion_o.stop_between <= (item_r.pattern != `PDS_PAT_CPATH); // see [RL19]
        aux_code_o            <= item_r.aux_code; // see [RL7]
        arc_point_o           <= item_r.arc; // see [RL6]
        arc_center_o          <= (item_r.method == `PDS_CM_CIRC_CTR);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= (state_r != PDS_IDLE) || start_req; // see [RL15]
    end
  end

  // Sticky events: set wins over a write-one clear
  assign ev[`PDS_IRQ_DONE] = (state_r == PDS_DWELL) && dwell_done;
  assign ev[`PDS_IRQ_END]  = (state_r == PDS_DWELL) && dwell_done &&
                             (item_r.pattern == `PDS_PAT_INDEP || at_last);
  assign ev[`PDS_IRQ_STEP] = (state_r == PDS_NEXT);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_r <= '0;
    end else begin
      if (we_i && addr_i == 16'(`PDS_ADDR_IRQ)) begin
        irq_r <= (irq_r & ~wdata_i[`PDS_IRQ_W-1:0]) | ev;
      end else begin
        irq_r <= irq_r | ev;
      end
    end
  end

  assign irq_o = |(irq_r & mask_r);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 32'h0;
    end else if (re_i) begin
      case (addr_i)
        16'(`PDS_ADDR_CTRL):  rdata_o <= {31'h0, enable_r};
        16'(`PDS_ADDR_START): rdata_o <= 32'(start_idx_r);
        16'(`PDS_ADDR_STAT):  rdata_o <= {27'h0, state_r};
        16'(`PDS_ADDR_IRQ):   rdata_o <= 32'(irq_r);
        16'(`PDS_ADDR_MASK):  rdata_o <= 32'(mask_r);
        16'(`PDS_ADDR_CUR):   rdata_o <= 32'(cur_r);
        16'(`PDS_ADDR_AUX):   rdata_o <= {16'h0, aux_code_o};
        default:              rdata_o <= 32'h0;
      endcase
    end else begin
      rdata_o <= 32'h0;
    end
  end

  a_chain_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_r == PDS_NEXT |=> cur_r == $past(cur_r) + `PDS_IDX_W'(1)) // see [RL18]
    else $error("index did not advance by one");
  a_indep_stop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_r == PDS_DWELL && dwell_done &&
    item_r.pattern == `PDS_PAT_INDEP |=> state_r == PDS_IDLE) // see [RL9]
    else $error("independent item did not end sequencing");
  a_last_stop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_r == PDS_NEXT |-> cur_r < `PDS_IDX_W'(ITEMS)) // see [RL14]
    else $error("chained past the highest item");
  a_path_nodwell: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_r == PDS_MOVE && move_done_i && !at_last &&
    item_r.pattern == `PDS_PAT_CPATH |=> state_r == PDS_NEXT) // see [RL17]
    else $error("continuous path waited");
  a_pos_dwell: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_r == PDS_MOVE && move_done_i &&
    item_r.pattern == `PDS_PAT_CPOS |=> state_r == PDS_DWELL) // see [RL11]
    else $error("continuous positioning skipped dwell");
  a_busy_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    start_req |=> busy_o [*2]) // see [RL15]
    else $error("busy missing after start");
  a_auto_next: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_r == PDS_NEXT |=> state_r == PDS_FETCH ##1 state_r == PDS_MOVE) // see [RL12]
    else $error("next item not started");
  a_accel_pick: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_r == PDS_MOVE && $past(state_r) == PDS_FETCH |=>
    motion_o.accel_time == accel_v_r[item_r.accel_sel]) // see [RL3]
    else $error("wrong acceleration time");
endmodule
`default_nettype wire

// ---- pds_motion_model.sv ----
// Motor drive side model: takes a motion command, runs, reports done
// Assumes the sequencer pulses motion valid for one cycle per item
`timescale 1ns/1ps
`default_nettype none
module pds_motion_model
  import pds_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  // Command and answer
  input  wire pds_pkg::pds_motion_t motion_i,
  input  wire logic [3:0]           lat_i,
  output logic                      done_o,
  output logic                      zero_o
);
  logic [3:0] cnt_r;
  logic       run_r;
  // Speed is back at zero by the time done is reported
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_r  <= 1'b0;
      cnt_r  <= 4'h0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (motion_i.valid) begin
        run_r <= 1'b1;
        cnt_r <= lat_i;
      end else if (run_r && cnt_r == 4'h0) begin
        run_r  <= 1'b0;
        done_o <= 1'b1;
      end else if (run_r) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
  assign zero_o = !run_r;
endmodule
`default_nettype wire

// ---- pds_sequencer_bench.sv ----
// Self-checking bench of the positioning data sequencer
// Assumes pds_motion_model stands in for the drive unit
`timescale 1ns/1ps
`default_nettype none
`include "pds_params.svh"
module pds_sequencer_bench;
  import pds_pkg::*;
  localparam int TICK = 8;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [15:0] addr_i = 16'h0000;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic        we_i = 1'b0;
  logic        re_i = 1'b0;
  logic [31:0] rdata_o, arc_point_o, seed, acc_v [4], dec_v [4];
  logic [15:0] aux_code_o;
  logic        move_done_i, speed_zero_i, busy_o, arc_center_o, irq_o;
  logic [3:0]  lat = 4'h2;
  logic        vld_d = 1'b0;
  pds_motion_t motion_o;
  pds_motion_t mq [$];
  logic [48:0] aq [$];
  pds_item_t   tab [1:`PDS_ITEMS];
  int          gq [$];
  int          n_errors = 0, checks_done = 0, cyc = 0, t_done = 0;

  always #2.5 clk_i = ~clk_i;

  pds_sequencer #(.ITEMS(`PDS_ITEMS), .TICK_CYC(TICK)) DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .motion_o(motion_o),
    .move_done_i(move_done_i), .speed_zero_i(speed_zero_i),
    .busy_o(busy_o), .aux_code_o(aux_code_o), .arc_point_o(arc_point_o),
    .arc_center_o(arc_center_o), .irq_o(irq_o));
  pds_motion_model MODEL (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .motion_i(motion_o), .lat_i(lat), .done_o(move_done_i),
    .zero_o(speed_zero_i));

  // Fields settle one cycle after the valid pulse
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (move_done_i === 1'b1) t_done <= cyc;
    if (motion_o.valid === 1'b1) gq.push_back(cyc - t_done);
    if (vld_d) begin
      mq.push_back(motion_o);
      aq.push_back({arc_center_o, arc_point_o, aux_code_o});
    end
    vld_d <= (motion_o.valid === 1'b1);
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic void rnd(output logic [31:0] r);
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c1_1db7 : 32'h0);
    r = seed;
  endfunction
  task automatic chk(input logic [31:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic wait_busy(input logic lvl, input int bound);
    for (int i = 0; i < bound && busy_o !== lvl; i++) @(posedge clk_i) #1;
    if (busy_o !== lvl) begin
      n_errors++;
      $display("[ERR] %0t busy wait ran out", $time);
      report_and_stop();
    end
  endtask
  task automatic mk(input int n, input logic [1:0] pat,
                    input logic [3:0] meth, input logic [15:0] dw,
                    input logic [31:0] tgt);
    pds_item_t it;
    logic [15:0] b;
    logic [31:0] r;
    b = 16'(32'h80 + (n - 1) * 32);
    it.pattern = pat;
    it.method = meth;
    it.accel_sel = 2'(n);
    it.decel_sel = 2'(n + 1);
    it.target = tgt;
    it.dwell = dw;
    rnd(it.arc);
    rnd(it.speed);
    rnd(r);
    it.aux_code = r[15:0];
    tab[n] = it;
    wr(b, {20'h0, it.decel_sel, it.accel_sel, meth, 2'b00, pat});
    wr(b + 16'h4, tgt);
    wr(b + 16'h8, it.arc);
    wr(b + 16'hc, it.speed);
    wr(b + 16'h10, {16'h0, dw});
    wr(b + 16'h14, {16'h0, it.aux_code});
  endtask
  task automatic run(input int n, cnt, input bit again, input string nm);
    pds_motion_t m;
    logic [48:0] a;
    int g, i, pd;
    wr(16'(`PDS_ADDR_START), 32'(n));
    wait_busy(1'b1, 6);
    if (again) wr(16'(`PDS_ADDR_START), 32'(n));
    wait_busy(1'b0, 3000);
    pd = cyc - t_done;
    for (int k = 0; k < cnt && mq.size() > 0; k++) begin
      i = n + k;
      m = mq.pop_front();
      a = aq.pop_front();
      g = gq.pop_front();
      chk(m.target, tab[i].target, "target");
      chk(m.speed, tab[i].speed, "speed");
      chk(m.accel_time, acc_v[tab[i].accel_sel], "accel");
      chk(m.decel_time, dec_v[tab[i].decel_sel], "decel");
      chk(32'(m.stop_between), 32'(tab[i].pattern != 2'h3),
          "stop");
      chk(32'(a[15:0]), 32'(tab[i].aux_code), "aux");
      chk(a[47:16], tab[i].arc, "arc");
      chk(32'(a[48]), 32'(tab[i].method == 4'h9), "centre");
      if (k > 0 && tab[i - 1].pattern == 2'h1)
        chk(32'(g >= tab[i - 1].dwell * TICK), 1, "dwell gap");
      if (k > 0 && tab[i - 1].pattern == 2'h3)
        chk(32'(g < TICK), 1, "path gap");
    end
    chk(32'(pd >= tab[n + cnt - 1].dwell * TICK), 1,
        "end dwell");
    chk(32'(mq.size()), 32'(0), "motion count");
    $display("test %s done", nm);
  endtask
  task automatic no_start(input int n);
    wr(16'(`PDS_ADDR_START), 32'(n));
    repeat (6) @(posedge clk_i);
    #1 chk(32'(busy_o), 0, "refused start");
    chk(32'(mq.size()), 0, "refused motion");
  endtask

  initial begin
    logic [31:0] d, r;
    seed = 32'h5668bb49;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1 chk(32'(busy_o), 0, "busy reset");
    chk(32'(irq_o), 0, "irq reset");
    for (int j = 0; j < 4; j++) begin
      rnd(acc_v[j]);
      rnd(dec_v[j]);
      wr(16'(`PDS_ADDR_ACCV + 4 * j), acc_v[j]);
      wr(16'(`PDS_ADDR_DECV + 4 * j), dec_v[j]);
    end
    rd(16'h003c, d);
    chk(d, 32'h0, "unmapped read");
    no_start(1);
    wr(16'(`PDS_ADDR_CTRL), 32'h1);
    rnd(r);
    mk(1, 2'h0, 4'h1, 16'h2, r);
    run(1, 1, 1'b0, "single");
    rd(16'(`PDS_ADDR_IRQ), d);
    chk(32'(d[0]), 1, "done event");
    chk(32'(irq_o), 0, "masked irq");
    wr(16'(`PDS_ADDR_MASK), 32'h1);
    #1 chk(32'(irq_o), 1, "irq raised");
    wr(16'(`PDS_ADDR_IRQ), 32'h7);
    #1 chk(32'(irq_o), 0, "irq cleared");
    // Last item of a chain carries the independent code
    mk(2, 2'h1, 4'h1, 16'h3, r);
    mk(3, 2'h3, 4'h1, 16'h3, ~r);
    mk(4, 2'h1, 4'h9, 16'h0, r);
    mk(5, 2'h0, 4'h8, 16'h1, ~r);
    run(2, 4, 1'b1, "chain");
    rd(16'(`PDS_ADDR_CUR), d);
    chk(d, 32'd5, "index");
    mk(599, 2'h3, 4'h1, 16'h0, r);
    mk(600, 2'h3, 4'h1, 16'h0, ~r);
    run(599, 2, 1'b0, "top end");
    mk(600, 2'h1, 4'h1, 16'h0, r);
    run(600, 1, 1'b0, "top alone");
    mk(6, 2'h0, 4'h1, 16'h0, 32'h0);
    run(6, 1, 1'b0, "zero move");
    no_start(0);
    no_start(601);
    for (int j = 7; j < 11; j++) begin
      rnd(r);
      lat = r[7:4] | 4'h1;
      mk(j, 2'h0, r[3:0] & 4'h9, {14'h0, r[9:8]}, r);
      run(j, 1, 1'b0, "random");
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
